// ---- otss_top.sv ----
// oscillator trim, spread-spectrum and power-mode control
// assumes registers written over a plain one-cycle strobe port on core_clk
//
// Notes on behaviour
// - interval zero passes fine trim directly
// - amplitude code selects 4, 8, 16, 32
// - swept word spans fine trim plus/minus amplitude
// - interval sets cycles between sweep updates
// - full sweep lasts 4*interval*amp
// - swept word clipped to 0..255
// - coarse register holds interval, amplitude, coarse
// - reset reloads coarse and fine defaults
// - fast oscillator off only in stop
// - oscillator enable changes glitch free
// - main regulator on in every mode but sleep
// - main regulator on after reset
// - regulator trim resets to all ones
// - higher fine trim means lower frequency
// - slow oscillator always runs, selectable
//
// Our own choice: the plain strobed port.
`default_nettype none
module otss_top (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  output logic      [7:0]  regulatorTrim,
  output logic      [1:0]  coarseTrim,
  output logic      [7:0]  effectiveFineTrim,
  output logic             fastOscEn,
  output logic             fastOscStable,
  output logic             slowOscEn,
  output logic             sysClkSlowSel,
  output logic             wakeTimerSlowSel,
  output logic             mainRegEn,
  output logic             backupRegEn
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] regTrim_q;
  logic [7:0] coarse_q;
  logic [7:0] fine_q;
  logic [7:0] power_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [3:0] settle_q;
  logic [3:0] settle_d;
  logic       oscEn_q;
  logic       mainEn_q;

  // address decode
  wire selRegTrim = (regAddr == otss_pkg::REG_TRIM_ADDR);
  wire selCoarse  = (regAddr == otss_pkg::COARSE_ADDR);
  wire selFine    = (regAddr == otss_pkg::FINE_ADDR);
  wire selPower   = (regAddr == otss_pkg::POWER_MODE_ADDR);
  wire selStatus  = (regAddr == otss_pkg::STATUS_ADDR);

  // register writes; calibration is lost on reset by design
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regTrim_q <= otss_pkg::REG_TRIM_RST;
      coarse_q  <= otss_pkg::COARSE_RST;
      fine_q    <= otss_pkg::FINE_RST;
      power_q   <= otss_pkg::POWER_RST;
    end else if (clkEn && regWr) begin
      if (selRegTrim) regTrim_q <= regWdata;
      if (selCoarse)  coarse_q  <= regWdata;
      if (selFine)    fine_q    <= regWdata;
      if (selPower)   power_q   <= regWdata;
    end
  end

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  wire [3:0] interval = coarse_q[otss_pkg::INTERVAL_HI:otss_pkg::INTERVAL_LO];
  wire [1:0] ampCode  = coarse_q[otss_pkg::AMP_HI:otss_pkg::AMP_LO];
  wire [5:0] ampValue = (ampCode == 2'h3) ? otss_pkg::AMP_CODE3 :
                        (ampCode == 2'h2) ? otss_pkg::AMP_CODE2 :
                        (ampCode == 2'h1) ? otss_pkg::AMP_CODE1 : otss_pkg::AMP_CODE0;
  wire [2:0] mode     = power_q[otss_pkg::MODE_HI:0];
  wire inStop  = (mode == otss_pkg::PM_STOP);
  wire inSleep = (mode == otss_pkg::PM_SLEEP);
  wire inNormal = !inStop && !inSleep;

  // sweeper drives the oscillator word; larger word, slower clock
  otss_sweeper #(
    .WIDTH (8)
  ) u_sweeper (
    .core_clk  (core_clk),
    .rst       (rst),
    .clkEn     (clkEn),
    .interval  (interval),
    .amplitude (ampValue),
    .fineTrim  (fine_q),
    .effTrim   (effectiveFineTrim)
  );

  // ----------------------------------------
  // power control
  // ----------------------------------------
  // registered enables so the analog side sees clean edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      oscEn_q  <= 1'b1;
      mainEn_q <= 1'b1;
      settle_q <= 4'h0;
    end else if (clkEn) begin
      oscEn_q  <= !inStop;
      mainEn_q <= inNormal || inStop;
      settle_q <= settle_d;
    end
  end
  // settle count restarts whenever oscillator is off
  assign settle_d = !oscEn_q ? 4'h0 :
                    (settle_q == 4'(otss_pkg::SETTLE_CYCLES)) ? settle_q : settle_q + 4'h1;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  assign rdata_d = selRegTrim ? regTrim_q :
                   selCoarse  ? coarse_q :
                   selFine    ? fine_q :
                   selPower   ? power_q :
                   selStatus  ? {5'h00, fastOscStable, oscEn_q, mainEn_q} : 8'h00;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (clkEn) begin
      rdata_q <= regRd ? rdata_d : 8'h00;
    end
  end

  assign regRdata         = rdata_q;
  assign regulatorTrim    = regTrim_q;
  assign coarseTrim       = coarse_q[otss_pkg::COARSE_HI:otss_pkg::COARSE_LO];
  assign fastOscEn        = oscEn_q;
  assign fastOscStable    = (settle_q == 4'(otss_pkg::SETTLE_CYCLES));
  assign slowOscEn        = 1'b1;
  assign sysClkSlowSel    = power_q[otss_pkg::SLOW_SEL_BIT];
  assign wakeTimerSlowSel = power_q[otss_pkg::WAKE_SEL_BIT];
  assign mainRegEn        = mainEn_q;
  assign backupRegEn      = !mainEn_q;
endmodule // otss_top
`default_nettype wire

// ---- otss_pkg.sv ----
// package for the oscillator trim and spread-spectrum block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package otss_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [15:0] REG_TRIM_ADDR   = 16'ha000;
  localparam logic [15:0] COARSE_ADDR     = 16'ha001;
  localparam logic [15:0] FINE_ADDR       = 16'ha002;
  localparam logic [15:0] POWER_MODE_ADDR = 16'ha003;
  localparam logic [15:0] STATUS_ADDR     = 16'ha004;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] REG_TRIM_RST = 8'hff;
  localparam logic [7:0] COARSE_RST   = 8'h02;
  localparam logic [7:0] FINE_RST     = 8'h8e;
  localparam logic [7:0] POWER_RST    = 8'h00;
  // ----------------------------------------
  // coarse register fields
  // ----------------------------------------
  localparam int INTERVAL_HI = 7;
  localparam int INTERVAL_LO = 4;
  localparam int AMP_HI      = 3;
  localparam int AMP_LO      = 2;
  localparam int COARSE_HI   = 1;
  localparam int COARSE_LO   = 0;
  localparam logic [3:0] INTERVAL_OFF = 4'h0;
  localparam logic [7:0] TRIM_MAX     = 8'hff;
  // amplitude per code
  localparam logic [5:0] AMP_CODE0 = 6'h04;
  localparam logic [5:0] AMP_CODE1 = 6'h08;
  localparam logic [5:0] AMP_CODE2 = 6'h10;
  localparam logic [5:0] AMP_CODE3 = 6'h20;
  // ----------------------------------------
  // power modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    PM_NORMAL = 3'h0,
    PM_PMM    = 3'h1,
    PM_IDLE   = 3'h3,
    PM_STOP   = 3'h2,
    PM_SLEEP  = 3'h6
  } otss_mode_type;
  localparam int MODE_HI       = 2;
  localparam int SLOW_SEL_BIT  = 3;
  localparam int WAKE_SEL_BIT  = 4;
  // oscillator restart settle
  localparam int SETTLE_CYCLES = 10;
endpackage : otss_pkg
`default_nettype wire

// ---- otss_sweeper.sv ----
// triangle-wave sweeper for the fine trim
// assumes the caller gives a synchronous clock, reset and enable
`default_nettype none
module otss_sweeper #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire logic [3:0]       interval,
  input  wire logic [5:0]       amplitude,
  input  wire logic [WIDTH-1:0] fineTrim,
  output logic      [WIDTH-1:0] effTrim
);
  // only the 8-bit trim word is served; refused at elaboration
  if (WIDTH != 8) begin : g_width_chk
    $error("otss_sweeper supports only 8-bit trim");
  end

  logic [3:0]  tickCnt_q;
  logic [3:0]  tickCnt_d;
  logic signed [6:0] offset_q;
  logic signed [6:0] offset_d;
  logic        up_q;
  logic        up_d;
  logic [WIDTH-1:0] effTrim_q;
  logic [WIDTH-1:0] effTrim_d;

  // ----------------------------------------
  // step timing and direction
  // ----------------------------------------
  wire sweepOn = (interval != otss_pkg::INTERVAL_OFF);
  wire stepNow = sweepOn && (tickCnt_q >= interval - 4'h1);
  wire signed [6:0] ampS = $signed({1'b0, amplitude});
  wire atTop   = (offset_q >= ampS);
  wire atBot   = (offset_q <= -ampS);
  // reverse at each limit; a shrunk amplitude pulls offset back in
  // parked sweeper forgets its direction so every sweep starts upward
  assign up_d = !sweepOn ? 1'b1 : (atTop ? 1'b0 : (atBot ? 1'b1 : up_q));
  assign offset_d = !sweepOn ? 7'sd0 : (!stepNow ? offset_q :
                    (up_d ? offset_q + 7'sd1 : offset_q - 7'sd1));
  assign tickCnt_d = (!sweepOn || stepNow) ? 4'h0 : tickCnt_q + 4'h1;

  // sum widened so clipping sees true sign
  wire signed [9:0] sum = $signed({2'b00, fineTrim}) + 10'(offset_q);
  assign effTrim_d = !sweepOn ? fineTrim :
                     (sum < 10'sd0) ? '0 :
                     (sum > $signed({2'b00, otss_pkg::TRIM_MAX})) ? otss_pkg::TRIM_MAX : sum[WIDTH-1:0];

  // short registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tickCnt_q <= 4'h0;
      offset_q  <= 7'sd0;
      up_q      <= 1'b1;
      effTrim_q <= otss_pkg::FINE_RST;
    end else if (clkEn) begin
      tickCnt_q <= tickCnt_d;
      offset_q  <= offset_d;
      up_q      <= up_d;
      effTrim_q <= effTrim_d;
    end
  end
  assign effTrim = effTrim_q;
endmodule // otss_sweeper
`default_nettype wire

// ---- otss_checker.sv ----
// otss_checker.sv: port assertions for otss_top
// assumes one core_clk domain, sync active-high rst, clkEn held high
`default_nettype none
module otss_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic [15:0] regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWr,
  input wire logic [7:0]  regulatorTrim,
  input wire logic [1:0]  coarseTrim,
  input wire logic [7:0]  effectiveFineTrim,
  input wire logic        fastOscEn,
  input wire logic        fastOscStable,
  input wire logic        slowOscEn,
  input wire logic        mainRegEn,
  input wire logic        backupRegEn
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----
  // properties
  // -----
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_trim_write: assert property (clkEn && regWr && regAddr == otss_pkg::REG_TRIM_ADDR |=> regulatorTrim == $past(regWdata))
    else $error("regulator trim write lost");
  chk_coarse_field: assert property (clkEn && regWr && regAddr == otss_pkg::COARSE_ADDR |=> coarseTrim == $past(regWdata[1:0]))
    else $error("coarse trim field wrong");
  chk_osc_stop: assert property (clkEn && regWr && regAddr == otss_pkg::POWER_MODE_ADDR |=> ##1
    fastOscEn == ($past(regWdata[2:0], 2) != otss_pkg::PM_STOP))
    else $error("fast osc enable wrong for mode");
  chk_reg_sleep: assert property (clkEn && regWr && regAddr == otss_pkg::POWER_MODE_ADDR |=> ##1
    mainRegEn == ($past(regWdata[2:0], 2) != otss_pkg::PM_SLEEP))
    else $error("main regulator wrong for mode");
  chk_backup_excl: assert property (backupRegEn != mainRegEn)
    else $error("both or no regulators on");
  chk_slow_on: assert property (slowOscEn)
    else $error("slow osc stopped");
  // stable must wait out the restart, but not for long
  chk_settle_wait: assert property ($rose(fastOscEn) |-> !fastOscStable [*8] ##[1:6] fastOscStable)
    else $error("osc stable flag timing wrong");
  chk_reset_vals: assert property ($fell(rst) |-> regulatorTrim == 8'hff && mainRegEn && effectiveFineTrim == 8'h8e)
    else $error("reset defaults wrong");
endmodule // otss_checker
bind otss_top otss_checker otss_checker_i (.core_clk, .rst, .clkEn, .regAddr, .regWdata, .regWr, .regulatorTrim, .coarseTrim,
  .effectiveFineTrim, .fastOscEn, .fastOscStable, .slowOscEn, .mainRegEn, .backupRegEn);
`default_nettype wire

// ---- tb_top.sv ----
// tb_top.sv: self-checking bench for otss_top
// assumes otss_pkg and the design compiled first; clkEn held high except for one swallowed-write check
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0, rst = 1, regWr = 0, regRd = 0, clkEn = 1;
  logic [15:0] regAddr = 0;
  logic [7:0]  regWdata = 0, regRdata, regulatorTrim, effectiveFineTrim;
  logic [1:0]  coarseTrim;
  logic        fastOscEn, fastOscStable, slowOscEn, sysClkSlowSel, wakeTimerSlowSel, mainRegEn, backupRegEn;
  int          mismatches = 0, cmp_count = 0;
  otss_pkg::otss_mode_type modes [6] = '{otss_pkg::PM_STOP, otss_pkg::PM_NORMAL, otss_pkg::PM_PMM,
    otss_pkg::PM_IDLE, otss_pkg::PM_SLEEP, otss_pkg::PM_NORMAL};
  // calibration points a host visits before its binary search
  logic [7:0]  calib [3] = '{8'h00, 8'hff, 8'h7f};
  otss_top otss_top_i (.core_clk, .rst, .clkEn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .regulatorTrim,
    .coarseTrim, .effectiveFineTrim, .fastOscEn, .fastOscStable, .slowOscEn, .sysClkSlowSel, .wakeTimerSlowSel,
    .mainRegEn, .backupRegEn);
  // 125 MHz clock
  initial forever #4 core_clk = ~core_clk;
  // -----
  // access tasks
  // -----
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'h0;
    #1 chk(regRdata, e);
  endtask
  // sweep from a parked fine trim; window covers a full period
  task automatic sweep(input logic [7:0] fine, cw, lo, hi);
    logic [7:0] mn, mx, prev;
    logic ok;
    int first;
    wr(otss_pkg::COARSE_ADDR, 8'h00);
    wr(otss_pkg::FINE_ADDR, fine);
    @(posedge core_clk);
    #1 chk(effectiveFineTrim, fine);
    wr(otss_pkg::COARSE_ADDR, cw);
    mn = 8'hff;
    mx = 8'h00;
    prev = fine;
    ok = 1'h1;
    first = 0;
    for (int k = 1; k <= 600; k++) begin
      @(posedge core_clk);
      #1;
      if (first == 0 && effectiveFineTrim != prev) first = k;
      if (effectiveFineTrim < mn) mn = effectiveFineTrim;
      if (effectiveFineTrim > mx) mx = effectiveFineTrim;
      ok = ok && (effectiveFineTrim - prev) inside {8'h00, 8'h01, 8'hff};
      prev = effectiveFineTrim;
    end
    chk(mn, lo);
    chk(mx, hi);
    chk({7'h00, ok}, 8'h01);
    // first step after interval cycles, plus the output register
    chk(8'(first), {4'h0, cw[7:4]} + 8'h01);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'h0;
    rd(otss_pkg::REG_TRIM_ADDR, 8'hff);
    rd(otss_pkg::COARSE_ADDR, 8'h02);
    rd(otss_pkg::FINE_ADDR, 8'h8e);
    chk({7'h00, mainRegEn}, 8'h01);
    rd(16'ha0ff, 8'h00);
    wr(otss_pkg::REG_TRIM_ADDR, 8'h00);
    rd(otss_pkg::REG_TRIM_ADDR, 8'h00);
    // a write while clkEn is low must be swallowed
    @(posedge core_clk);
    clkEn <= 1'h0;
    wr(otss_pkg::REG_TRIM_ADDR, 8'h5a);
    #1 chk(regulatorTrim, 8'h00);
    @(posedge core_clk);
    clkEn <= 1'h1;
    wr(otss_pkg::COARSE_ADDR, 8'h01);
    foreach (calib[j]) begin
      wr(otss_pkg::FINE_ADDR, calib[j]);
      @(posedge core_clk);
      #1 chk(effectiveFineTrim, calib[j]);
      chk({6'h00, coarseTrim}, 8'h01);
    end
    for (int a = 0; a < 4; a++) sweep(8'h80, {4'h1, a[1:0], 2'h1}, 8'h80 - (8'h04 << a), 8'h80 + (8'h04 << a));
    chk({6'h00, coarseTrim}, 8'h01);
    rd(otss_pkg::COARSE_ADDR, 8'h1d);
    sweep(8'hfe, 8'h24, 8'hf6, 8'hff);
    sweep(8'h02, 8'h14, 8'h00, 8'h0a);
    foreach (modes[i]) begin
      wr(otss_pkg::POWER_MODE_ADDR, {5'h00, modes[i]});
      repeat (2) @(posedge core_clk);
      #1 chk({7'h00, fastOscEn}, {7'h00, modes[i] != otss_pkg::PM_STOP});
      chk({7'h00, backupRegEn}, {7'h00, modes[i] == otss_pkg::PM_SLEEP});
    end
    // bounded wait, sampled off the edge that updates the flag
    for (int n = 0; n < 20 && fastOscStable !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk({7'h00, fastOscStable}, 8'h01);
    rd(otss_pkg::STATUS_ADDR, 8'h07);
    wr(otss_pkg::POWER_MODE_ADDR, 8'h18);
    #1 chk({5'h00, sysClkSlowSel, wakeTimerSlowSel, slowOscEn}, 8'h07);
    wr(otss_pkg::FINE_ADDR, 8'h11);
    rd(otss_pkg::FINE_ADDR, 8'h11);
    rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    rd(otss_pkg::COARSE_ADDR, 8'h02);
    rd(otss_pkg::FINE_ADDR, 8'h8e);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
